// ==== dv/rtc_board.sv ====
// Board side: strap resistors, address pin and data-line pull-up.
// Assumes the bench picks each strap level, some of them while enable is high.
`timescale 1ns/1ps
module rtc_board
  import rtc_pkg::*;
(
  // Choices made by the bench, plus the device's data-line enable
  input  wire rtc_pkg::rtc_lvl_t lvl [4],
  input  wire logic              a2_fitted,
  input  wire logic              a2_level,
  input  wire logic              host_sda_low,
  input  wire logic              control_bus_data_oe,
  // Pins seen by the device
  output logic [3:0]             str_hi,
  output logic [3:0]             str_lo,
  output logic                   addr_bit2_pin,
  output logic                   control_bus_data_pin
);
  // Resistor up reads high, down reads low, open reads neither
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      str_hi[i] = lvl[i] == RTC_LVL_HIGH;
      str_lo[i] = lvl[i] == RTC_LVL_LOW;
    end
  end
  // Open address pin falls to its pull-down
  assign addr_bit2_pin = a2_fitted & a2_level;
  // Open-drain wire: anyone may pull low, pull-up otherwise
  assign control_bus_data_pin = !(host_sda_low || control_bus_data_oe);
endmodule

// ==== dv/rtc_top_sva.sv ====
// Port checks for the strap and control-mode loader.
// Assumes each synchronised pin takes three clk edges to reach an output, four through the strap capture; retimer_mode takes one.
`timescale 1ns/1ps
module rtc_top_sva
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // Pins
  input wire logic       oper_enable_pin,
  input wire logic       signal_detect_enable,
  input wire logic       input_clock_valid,
  input wire logic       control_mode_pin,
  input wire logic       hotplug_in_sink,
  input wire logic       addr_bit2_pin,
  input wire logic       retimer_mode,
  // Outputs
  input wire logic       control_bus_data_oe,
  input wire logic       hotplug_out_source,
  input wire logic       power_down,
  input wire logic       standby,
  input wire logic       i2c_mode,
  input wire logic [1:0] deemph_sel,
  input wire logic [1:0] eq_sel,
  input wire logic [1:0] term_sel,
  input wire logic       lane_swap,
  input wire logic       lane_invert,
  input wire logic [6:0] bus_address,
  input wire logic [7:0] cfg_reg
);
  // ----
  // Pin history, so checks wait out the synchronisers
  // ----
  logic [5:0] b_q [1:4];
  logic [3:0] up_q;
  logic [3:0] hold_q;
  logic       st;
  always_ff @(posedge clk) begin
    b_q[1] <= {oper_enable_pin, signal_detect_enable, input_clock_valid,
               control_mode_pin, hotplug_in_sink, addr_bit2_pin};
    b_q[2] <= b_q[1];
    b_q[3] <= b_q[2];
    b_q[4] <= b_q[3];
    up_q   <= !rst_b ? 4'h0 : up_q + {3'h0, up_q != 4'hf};
    hold_q <= (!rst_b || !oper_enable_pin || control_mode_pin) ? 4'h0 : hold_q + {3'h0, hold_q != 4'hf};
  end
  // Pins held four edges, well clear of reset
  assign st = up_q > 4'h5 && b_q[1] == b_q[2] && b_q[2] == b_q[3] && b_q[3] == b_q[4];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_pdown_level: assert property (st |-> power_down == !b_q[2][5])
    else $error("power_down does not follow enable");
  a_standby_cause: assert property (st |-> standby == (b_q[2][5] && b_q[2][4] && !b_q[2][3]))
    else $error("standby wrong");
  a_mode_follow: assert property (st |-> i2c_mode == b_q[2][2])
    else $error("i2c_mode wrong");
  a_hotplug_pass: assert property (st |-> hotplug_out_source == (b_q[2][1] && b_q[2][5]))
    else $error("hotplug_out_source wrong");
  a_addr_bits: assert property (st |-> bus_address[6:2] == {DEV_ADDR_HI, b_q[2][0]}
    && bus_address[0] == DEV_ADDR_B0 && (b_q[2][2] || !bus_address[1])) else $error("bus_address wrong");
  a_invert_gate: assert property (!retimer_mode [*3] |=> !lane_invert)
    else $error("lane_invert without retimer mode");
  a_term_resolved: assert property (term_sel != TERM_AUTO)
    else $error("term_sel left unresolved");
  a_oe_quiet: assert property (power_down [*2] |-> !control_bus_data_oe)
    else $error("data_oe active in power-down");
  a_snap_hold: assert property (hold_q > 4'h8 |=> $stable({deemph_sel, eq_sel, lane_swap}))
    else $error("strap settings moved after capture");
  a_cfg_steer: assert property ((($stable(cfg_reg) && i2c_mode) [*3]) ##0 (st && b_q[2][2] && b_q[2][5])
    |-> deemph_sel == cfg_reg[1:0] && eq_sel == cfg_reg[3:2]) else $error("settings differ from cfg_reg");

  c_standby: cover property (standby);
  c_invert: cover property (lane_invert);
  c_ack: cover property (control_bus_data_oe);
  c_i2c_swap: cover property (i2c_mode && lane_swap);
endmodule
bind rtc_top rtc_top_sva rtc_top_sva_inst (.*);

// ==== dv/test_rtc_top.sv ====
// Self-checking bench for the strap and control-mode loader.
// Assumes rtc_board for straps; the bench is the two-wire host.
`timescale 1ns/1ps
module test_rtc_top;
  import rtc_pkg::*;
  logic       clk, rst_b, lclk, scl, host_low, en, sde, icv, mode, r34, r2, rtm, hp, a2f, a2v, ack;
  logic       a2, sda, oe, hpo, pd, sb, im, lsw, linv;
  logic [3:0] s_hi, s_lo;
  logic [1:0] de, eq, te;
  logic [6:0] ba;
  logic [7:0] cfg, d, m;
  rtc_lvl_t   lvl [4];
  rtc_lvl_t   sv [4];
  int         n_fail, samples_checked, seed;

  rtc_top rtc_top_inst (
    .clk(clk), .rst_b(rst_b), .control_bus_clock_pin(scl), .control_bus_data_pin(sda),
    .control_bus_data_oe(oe), .oper_enable_pin(en), .signal_detect_enable(sde),
    .input_clock_valid(icv), .control_mode_pin(mode), .addr_bit2_pin(a2),
    .deemph_strap_hi(s_hi[0]), .deemph_strap_lo(s_lo[0]),
    .equalizer_strap_addr_bit1_hi(s_hi[1]), .equalizer_strap_addr_bit1_lo(s_lo[1]),
    .termination_strap_hi(s_hi[2]), .termination_strap_lo(s_lo[2]),
    .lane_swap_polarity_strap_hi(s_hi[3]), .lane_swap_polarity_strap_lo(s_lo[3]),
    .rate_above_3g4(r34), .rate_above_2g(r2), .retimer_mode(rtm), .hotplug_in_sink(hp),
    .hotplug_out_source(hpo), .power_down(pd), .standby(sb), .i2c_mode(im), .deemph_sel(de),
    .eq_sel(eq), .term_sel(te), .lane_swap(lsw), .lane_invert(linv), .bus_address(ba), .cfg_reg(cfg));
  rtc_board rtc_board_inst (.lvl(lvl), .a2_fitted(a2f), .a2_level(a2v), .host_sda_low(host_low),
    .control_bus_data_oe(oe), .str_hi(s_hi), .str_lo(s_lo), .addr_bit2_pin(a2), .control_bus_data_pin(sda));

  // ----
  // Clocks: core 4 ns, link timebase 15 ns at an odd phase
  // ----
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3.1;
    forever #7.5 lclk = ~lclk;
  end

  // Expected decode of one strap; auto termination uses live rates
  function automatic logic [1:0] exp_of(int s, rtc_lvl_t l);
    case (s)
      0: return l == RTC_LVL_LOW ? DEEMPH_M2DB : l == RTC_LVL_MID ? DEEMPH_0DB : DEEMPH_RSVD;
      1: return l == RTC_LVL_LOW ? EQ_FIXED_7P5 : l == RTC_LVL_MID ? EQ_ADAPTIVE : EQ_FIXED_14;
      2: return l == RTC_LVL_HIGH ? TERM_NONE : (l == RTC_LVL_LOW || r34) ? TERM_75_150 :
                r2 ? TERM_150_300 : TERM_NONE;
      default: return l == RTC_LVL_LOW ? LANE_SWAP : l == RTC_LVL_HIGH ? LANE_INVERT : LANE_NORMAL;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_straps();
    logic [1:0] t;
    t = exp_of(3, sv[3]);
    chk("deemph", {6'h0, exp_of(0, sv[0])}, {6'h0, de});
    chk("eq", {6'h0, exp_of(1, sv[1])}, {6'h0, eq});
    chk("term", {6'h0, exp_of(2, sv[2])}, {6'h0, te});
    chk("lane", {6'h0, t == LANE_SWAP, t == LANE_INVERT && rtm}, {6'h0, lsw, linv});
    chk("standby", {7'h0, sde & !icv}, {7'h0, sb});
    chk("hp_out", {7'h0, hp}, {7'h0, hpo});
    chk("pd_mode", 8'h0, {6'h0, pd, im});
  endtask

  // ----
  // Two-wire host; the bus clock only moves inside frames
  // ----
  task automatic tk();
    repeat (4) @(posedge lclk);
  endtask
  task automatic tw_byte(input logic [7:0] b, output logic a);
    for (int i = 0; i < 9; i++) begin
      tk();
      host_low = i < 8 ? !b[7 - i] : 1'b0;
      tk();
      scl = 1'b1;
      tk();
      a = oe;
      scl = 1'b0;
    end
  endtask
  task automatic tw_write(input logic [7:0] a0, input logic [7:0] dv, output logic ok);
    logic k1, k2, k3;
    tk();
    host_low = 1'b1;
    tk();
    scl = 1'b0;
    tw_byte(a0, k1);
    tw_byte(CFG_REG_OFS, k2);
    tw_byte(dv, k3);
    tk();
    host_low = 1'b1;
    tk();
    scl = 1'b1;
    tk();
    host_low = 1'b0;
    ok = k1 & k2 & k3;
  endtask

  // Hang guard, well past the expected run
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end

  initial begin
    seed = 32'hb263;
    n_fail = 0;
    samples_checked = 0;
    {rst_b, en, sde, icv, mode, r34, r2, rtm, hp, a2f, a2v, host_low} = 12'h0;
    scl = 1'b1;
    m = CFG_REG_RESET;
    foreach (lvl[j]) lvl[j] = RTC_LVL_MID;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    // Strap mode: every level on every strap, then straps moved after capture
    for (int k = 0; k < 6; k++) begin
      @(negedge clk);
      en = 1'b0;
      sde = k[0];
      icv = k[1];
      hp = 1'($random(seed));
      r34 = 1'($random(seed));
      r2 = 1'($random(seed));
      rtm = 1'($random(seed));
      foreach (lvl[j]) lvl[j] = rtc_lvl_t'((k + j) % 3);
      sv = lvl;
      repeat (8) @(negedge clk);
      chk("pd_off", 8'h2, {6'h0, pd, hpo});
      en = 1'b1;
      repeat (12) @(negedge clk);
      check_straps();
      foreach (lvl[j]) lvl[j] = rtc_lvl_t'((k + j + 1) % 3);
      repeat (12) @(negedge clk);
      check_straps();
    end
    // Two-wire mode: address pins, writes, a read and a wrong address refused
    mode = 1'b1;
    a2f = 1'b1;
    a2v = 1'b1;
    lvl[1] = RTC_LVL_HIGH;
    repeat (12) @(negedge clk);
    chk("addr", {1'b0, DEV_ADDR_HI, 2'h3, DEV_ADDR_B0}, {1'b0, ba});
    for (int w = 0; w < 4; w++) begin
      d = 8'($random(seed)) & (w[0] ? 8'h79 : 8'hb6);
      tw_write({DEV_ADDR_HI, 1'b1, w != 3, DEV_ADDR_B0, w == 2}, d, ack);
      if (w < 2) m = d;
      repeat (8) @(negedge clk);
      chk("ack", {7'h0, w < 2}, {7'h0, ack});
      chk("cfg", m, cfg);
      chk("de_eq_i2c", {4'h0, m[3:0]}, {4'h0, eq, de});
      chk("term_i2c", {6'h0, m[5:4] == 2'h3 ? exp_of(2, RTC_LVL_MID) : m[5:4]}, {6'h0, te});
      chk("lane_i2c", {6'h0, m[7:6] == LANE_SWAP, m[7:6] == LANE_INVERT && rtm}, {6'h0, lsw, linv});
    end
    // Strap mode: register still written but straps keep priority
    mode = 1'b0;
    a2f = 1'b0;
    repeat (12) @(negedge clk);
    d = ~m;
    tw_write({DEV_ADDR_HI, 2'h0, DEV_ADDR_B0, 1'b0}, d, ack);
    repeat (8) @(negedge clk);
    chk("cfg_strap", d, cfg);
    chk("ack_strap", 8'h1, {7'h0, ack});
    check_straps();
    // Enable dropped while the device acknowledges: frame abandoned, register cleared
    fork
      tw_write({DEV_ADDR_HI, 2'h0, DEV_ADDR_B0, 1'b0}, 8'h5a, ack);
      begin
        wait (oe);
        @(negedge clk);
        en = 1'b0;
        repeat (8) @(negedge clk);
        en = 1'b1;
      end
    join
    repeat (8) @(negedge clk);
    chk("ack_cut", 8'h0, {7'h0, ack});
    chk("cfg_clear", CFG_REG_RESET, cfg);
    end_of_test();
  end
endmodule

// ==== hdl/rtc_pkg.sv ====
// Constants shared by the retimer strap and control-mode loader.
// Assumes a single core clock plus the two-wire bus clock pin.
package rtc_pkg;

  // ----------------------------------------
  // Three-level strap levels
  // ----------------------------------------
  typedef enum logic [1:0] {RTC_LVL_LOW, RTC_LVL_MID, RTC_LVL_HIGH} rtc_lvl_t;

  // ----------------------------------------
  // Decoded setting codes
  // ----------------------------------------
  localparam logic [1:0] DEEMPH_0DB     = 2'h0;
  localparam logic [1:0] DEEMPH_M2DB    = 2'h1;
  localparam logic [1:0] DEEMPH_RSVD    = 2'h2;
  localparam logic [1:0] EQ_ADAPTIVE    = 2'h0;
  localparam logic [1:0] EQ_FIXED_7P5   = 2'h1;
  localparam logic [1:0] EQ_FIXED_14    = 2'h2;
  localparam logic [1:0] TERM_NONE      = 2'h0;
  localparam logic [1:0] TERM_75_150    = 2'h1;
  localparam logic [1:0] TERM_150_300   = 2'h2;
  localparam logic [1:0] TERM_AUTO      = 2'h3;
  localparam logic [1:0] LANE_NORMAL    = 2'h0;
  localparam logic [1:0] LANE_SWAP      = 2'h1;
  localparam logic [1:0] LANE_INVERT    = 2'h2;

  // ----------------------------------------
  // Two-wire slave: address and register map
  // ----------------------------------------
  localparam logic [3:0] DEV_ADDR_HI    = 4'hb;  // Upper address bits, arbitrary value
  localparam logic       DEV_ADDR_B0    = 1'h0;
  localparam logic [7:0] CFG_REG_OFS    = 8'h0a;
  localparam logic [7:0] CFG_REG_RESET  = 8'h00;
  localparam int         DEEMPH_LSB     = 0;
  localparam int         EQ_LSB         = 2;
  localparam int         TERM_LSB       = 4;
  localparam int         LANE_LSB       = 6;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

endpackage

// ==== hdl/rtc_top.sv ====
// Strap and control-mode configuration loader of a video-link retimer.
// Assumes straps arrive as high/low comparator pairs (neither = open), the two-wire
// bus clock pin clocks its own shift domain, and the datapath consumes the settings.
`timescale 1ns/1ps

module rtc_top (
  // Core clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Two-wire control bus
  input  wire logic       control_bus_clock_pin,
  input  wire logic       control_bus_data_pin,
  output logic            control_bus_data_oe,
  // Control pins
  input  wire logic       oper_enable_pin,
  input  wire logic       signal_detect_enable,
  input  wire logic       input_clock_valid,
  input  wire logic       control_mode_pin,
  input  wire logic       addr_bit2_pin,
  // Three-level straps, high and low comparator outputs
  input  wire logic       deemph_strap_hi,
  input  wire logic       deemph_strap_lo,
  input  wire logic       equalizer_strap_addr_bit1_hi,
  input  wire logic       equalizer_strap_addr_bit1_lo,
  input  wire logic       termination_strap_hi,
  input  wire logic       termination_strap_lo,
  input  wire logic       lane_swap_polarity_strap_hi,
  input  wire logic       lane_swap_polarity_strap_lo,
  // Datapath status
  input  wire logic       rate_above_3g4,
  input  wire logic       rate_above_2g,
  input  wire logic       retimer_mode,
  // Hot plug
  input  wire logic       hotplug_in_sink,
  output logic            hotplug_out_source,
  // Decoded settings
  output logic            power_down,
  output logic            standby,
  output logic            i2c_mode,
  output logic [1:0]      deemph_sel,
  output logic [1:0]      eq_sel,
  output logic [1:0]      term_sel,
  output logic            lane_swap,
  output logic            lane_invert,
  output logic [6:0]      bus_address,
  output logic [7:0]      cfg_reg
);
  import rtc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic rtc_lvl_t lvl3(input logic hi, input logic lo);
    if (hi) begin
      return RTC_LVL_HIGH;
    end else if (lo) begin
      return RTC_LVL_LOW;
    end
    return RTC_LVL_MID;
  endfunction

  // ----------------------------------------
  // Link domain: bits shift on bus clock rise
  // ----------------------------------------
  logic [7:0] link_shift_q;

  // No reset: the core reads it only after a synced rise, while it stands still
  always_ff @(posedge control_bus_clock_pin) begin
    link_shift_q <= {link_shift_q[6:0], control_bus_data_pin};
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 18;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;

  assign pins_raw = {control_bus_clock_pin, control_bus_data_pin, oper_enable_pin,
                     signal_detect_enable, input_clock_valid, control_mode_pin, addr_bit2_pin,
                     deemph_strap_hi, deemph_strap_lo, equalizer_strap_addr_bit1_hi,
                     equalizer_strap_addr_bit1_lo, termination_strap_hi, termination_strap_lo,
                     lane_swap_polarity_strap_hi, lane_swap_polarity_strap_lo,
                     rate_above_3g4, rate_above_2g, hotplug_in_sink};

  // Two flops per pin; only sync_q is read by logic
  always_ff @(posedge clk) begin
    meta_q <= pins_raw;
    sync_q <= meta_q;
  end

  logic scl_s, sda_s, oe_s, signal_detect_enable_s, clk_ok_s, mode_s, a2_s, de_hi_s, de_lo_s, eq_hi_s, eq_lo_s;
  logic tt_hi_s, tt_lo_s, sw_hi_s, sw_lo_s, r34_s, r2_s, hpd_s;
  assign {scl_s, sda_s, oe_s, signal_detect_enable_s, clk_ok_s, mode_s, a2_s, de_hi_s, de_lo_s,
          eq_hi_s, eq_lo_s, tt_hi_s, tt_lo_s, sw_hi_s, sw_lo_s, r34_s, r2_s, hpd_s} = sync_q;

  // ----------------------------------------
  // Enable, reset and strap capture
  // ----------------------------------------
  logic       captured_q, captured_d;
  logic [1:0] st_deemph_q, st_deemph_d;
  logic [1:0] st_eq_q, st_eq_d;
  logic [1:0] st_term_q, st_term_d;
  logic [1:0] st_lane_q, st_lane_d;
  logic       int_rst;

  // Enable held low wipes internal state, so every falling edge resets it
  assign int_rst = ~oe_s;

  always_comb begin
    captured_d  = captured_q;
    st_deemph_d = st_deemph_q;
    st_eq_d     = st_eq_q;
    st_term_d   = st_term_q;
    st_lane_d   = st_lane_q;
    if (int_rst) begin
      captured_d = 1'b0;
    end else if (!captured_q) begin
      // One snapshot on leaving reset or power-down, frozen afterwards
      captured_d = 1'b1;
      case (lvl3(de_hi_s, de_lo_s))
        RTC_LVL_LOW:  st_deemph_d = DEEMPH_M2DB;
        RTC_LVL_HIGH: st_deemph_d = DEEMPH_RSVD;
        default:      st_deemph_d = DEEMPH_0DB;
      endcase
      case (lvl3(eq_hi_s, eq_lo_s))
        RTC_LVL_LOW:  st_eq_d = EQ_FIXED_7P5;
        RTC_LVL_HIGH: st_eq_d = EQ_FIXED_14;
        default:      st_eq_d = EQ_ADAPTIVE;
      endcase
      case (lvl3(tt_hi_s, tt_lo_s))
        RTC_LVL_LOW:  st_term_d = TERM_75_150;
        RTC_LVL_HIGH: st_term_d = TERM_NONE;
        default:      st_term_d = TERM_AUTO;
      endcase
      case (lvl3(sw_hi_s, sw_lo_s))
        RTC_LVL_LOW:  st_lane_d = LANE_SWAP;
        RTC_LVL_HIGH: st_lane_d = LANE_INVERT;
        default:      st_lane_d = LANE_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      captured_q  <= 1'b0;
      st_deemph_q <= DEEMPH_0DB;
      st_eq_q     <= EQ_ADAPTIVE;
      st_term_q   <= TERM_AUTO;
      st_lane_q   <= LANE_NORMAL;
    end else begin
      captured_q  <= captured_d;
      st_deemph_q <= st_deemph_d;
      st_eq_q     <= st_eq_d;
      st_term_q   <= st_term_d;
      st_lane_q   <= st_lane_d;
    end
  end

  // ----------------------------------------
  // Two-wire slave (write only)
  // ----------------------------------------
  typedef enum logic [1:0] {RTC_ST_IDLE, RTC_ST_BITS, RTC_ST_ACK, RTC_ST_SKIP} rtc_st_t;
  rtc_st_t    st_q, st_d;
  logic       scl_prev_q, sda_prev_q;
  logic [3:0] bits_q, bits_d;
  logic [1:0] idx_q, idx_d;
  logic       ack_q, ack_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] cfg_q, cfg_d;
  logic       oe_drv_q, oe_drv_d;
  logic       scl_rise, scl_fall, start_c, stop_c;
  logic [6:0] my_addr;

  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_c  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_c   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  // Bit 1 follows the shared pin as a plain level only in two-wire mode
  assign my_addr  = {DEV_ADDR_HI, a2_s, (mode_s & eq_hi_s), DEV_ADDR_B0};

  always_comb begin
    st_d     = st_q;
    bits_d   = bits_q;
    idx_d    = idx_q;
    ack_d    = ack_q;
    ptr_d    = ptr_q;
    cfg_d    = cfg_q;
    oe_drv_d = oe_drv_q;
    if (start_c) begin
      st_d     = RTC_ST_BITS;
      bits_d   = 4'h0;
      idx_d    = 2'h0;
      ack_d    = 1'b0;
      oe_drv_d = 1'b0;
    end else if (stop_c) begin
      st_d     = RTC_ST_IDLE;
      oe_drv_d = 1'b0;
    end else begin
      case (st_q)
        RTC_ST_BITS: begin
          if (scl_rise) begin
            bits_d = bits_q + 4'h1;
            if (bits_q == BITS_PER_BYTE - 4'h1) begin
              // Byte is complete in the link shifter and stays put until next rise
              ack_d = 1'b1;
              case (idx_q)
                2'h0: ack_d = (link_shift_q == {my_addr, 1'b0});
                2'h1: ptr_d = link_shift_q;
                default: begin
                  // Writes land in either mode; the mux below decides use
                  if (ptr_q == CFG_REG_OFS) begin
                    cfg_d = link_shift_q;
                  end
                end
              endcase
            end
          end else if (scl_fall && bits_q == BITS_PER_BYTE) begin
            st_d     = ack_q ? RTC_ST_ACK : RTC_ST_SKIP;
            oe_drv_d = ack_q;
          end
        end
        RTC_ST_ACK: begin
          if (scl_fall) begin
            st_d     = RTC_ST_BITS;
            oe_drv_d = 1'b0;
            bits_d   = 4'h0;
            idx_d    = (idx_q == 2'h2) ? idx_q : idx_q + 2'h1;
          end
        end
        RTC_ST_IDLE, RTC_ST_SKIP: oe_drv_d = 1'b0;
        default: begin
          st_d     = RTC_ST_IDLE;
          oe_drv_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || int_rst) begin
      st_q       <= RTC_ST_IDLE;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      bits_q     <= 4'h0;
      idx_q      <= 2'h0;
      ack_q      <= 1'b0;
      ptr_q      <= 8'h00;
      cfg_q      <= CFG_REG_RESET;
      oe_drv_q   <= 1'b0;
    end else begin
      st_q       <= st_d;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      bits_q     <= bits_d;
      idx_q      <= idx_d;
      ack_q      <= ack_d;
      ptr_q      <= ptr_d;
      cfg_q      <= cfg_d;
      oe_drv_q   <= oe_drv_d;
    end
  end

  assign control_bus_data_oe = oe_drv_q;

  // ----------------------------------------
  // Setting selection and outputs
  // ----------------------------------------
  logic       out_pd_d, out_sb_d, out_i2c_d, out_hpd_d, out_swap_d, out_inv_d;
  logic [1:0] out_de_d, out_eq_d, out_tt_d, mode_term, mode_lane;

  always_comb begin
    out_pd_d  = ~oe_s;
    out_sb_d  = oe_s & signal_detect_enable_s & ~clk_ok_s;
    out_i2c_d = mode_s;
    // Register only steers strap features in two-wire mode
    out_de_d  = mode_s ? cfg_q[DEEMPH_LSB +: 2] : st_deemph_q;
    out_eq_d  = mode_s ? cfg_q[EQ_LSB +: 2] : st_eq_q;
    mode_term = mode_s ? cfg_q[TERM_LSB +: 2] : st_term_q;
    mode_lane = mode_s ? cfg_q[LANE_LSB +: 2] : st_lane_q;
    // Automatic termination tracks the live rate indication
    if (mode_term == TERM_AUTO) begin
      out_tt_d = r34_s ? TERM_75_150 : (r2_s ? TERM_150_300 : TERM_NONE);
    end else begin
      out_tt_d = mode_term;
    end
    out_swap_d = (mode_lane == LANE_SWAP);
    out_inv_d  = (mode_lane == LANE_INVERT) & retimer_mode;
    out_hpd_d  = hpd_s & oe_s;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      power_down         <= 1'b1;
      standby            <= 1'b0;
      i2c_mode           <= 1'b0;
      deemph_sel         <= DEEMPH_0DB;
      eq_sel             <= EQ_ADAPTIVE;
      term_sel           <= TERM_NONE;
      lane_swap          <= 1'b0;
      lane_invert        <= 1'b0;
      hotplug_out_source <= 1'b0;
      bus_address        <= 7'h00;
      cfg_reg            <= CFG_REG_RESET;
    end else begin
      power_down         <= out_pd_d;
      standby            <= out_sb_d;
      i2c_mode           <= out_i2c_d;
      deemph_sel         <= out_de_d;
      eq_sel             <= out_eq_d;
      term_sel           <= out_tt_d;
      lane_swap          <= out_swap_d;
      lane_invert        <= out_inv_d;
      hotplug_out_source <= out_hpd_d;
      bus_address        <= my_addr;
      cfg_reg            <= cfg_q;
    end
  end

endmodule
